// [logic/smba_pkg.sv]
`default_nettype none
package smba_pkg;
  // Address patterns seen in the first byte after START
  localparam logic [2:0] ADDR_HI    = 3'h2;   // Fixed upper bits 010 of the primary address
  localparam logic [6:0] ADDR_BCAST = 7'h30;  // Broadcast address 0110000
  localparam logic [6:0] ADDR_ARA   = 7'h0c;  // Alert response address 0001100
  // Register pointer and documented register offsets
  localparam int         PTR_W      = 5;
  localparam logic [4:0] REG_EVENT  = 5'h00;  // event_summary
  localparam logic [4:0] REG_ATTN   = 5'h1a;  // attention_command_pulses
  localparam int         ATTN_REL_BIT = 6;    // Release attention output
  localparam int         ATTN_CLR_BIT = 7;    // Clear all pending events
  // Bits per byte before the ninth (acknowledge) clock
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  // Reset values of the line samplers: idle bus is high
  localparam logic       LINE_IDLE  = 1'b1;

  // Transaction states, Gray coded along the usual path
  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_ADDR     = 4'h1,
    ST_ADDR_ACK = 4'h3,
    ST_CMD      = 4'h2,
    ST_CMD_ACK  = 4'h6,
    ST_DATA     = 4'h7,
    ST_DATA_ACK = 4'h5,
    ST_TX       = 4'h4,
    ST_TX_ACK   = 4'hc,
    ST_IGNORE   = 4'hd
  } smba_state_t;
endpackage : smba_pkg
`default_nettype wire

// [logic/smba_line_if.sv]
`timescale 1ns/100ps
`default_nettype none
// Synchronised bus lines and their events, from the sampler to the engine
interface smba_line_if;
  logic       scl;        // Clock line level
  logic       sda;        // Data input level
  logic       scl_rise;   // One-cycle pulses
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic [3:0] addr_sel;   // Address-select pin levels

  modport src (output scl, sda, scl_rise, scl_fall, start_det, stop_det, addr_sel);
  modport snk (input  scl, sda, scl_rise, scl_fall, start_det, stop_det, addr_sel);
endinterface : smba_line_if
`default_nettype wire

// [logic/smba_line_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module smba_line_sync (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Pins
  input  wire logic       scl_pin,
  input  wire logic       sda_pin,
  input  wire logic [3:0] addr_pins,
  // Events towards the engine
  smba_line_if.src        line
);
  typedef struct packed {
    logic       scl_m;
    logic       scl_s;
    logic       scl_d;
    logic       sda_m;
    logic       sda_s;
    logic       sda_d;
    logic [3:0] ad_m;
    logic [3:0] ad_s;
  } smba_sync_t;

  smba_sync_t q_r;
  smba_sync_t q_nxt;

  // Two flops per pin, then one delay stage for edge finding
  always_comb begin
    q_nxt       = q_r;
    q_nxt.scl_m = scl_pin;
    q_nxt.scl_s = q_r.scl_m;
    q_nxt.scl_d = q_r.scl_s;
    q_nxt.sda_m = sda_pin;
    q_nxt.sda_s = q_r.sda_m;
    q_nxt.sda_d = q_r.sda_s;
    q_nxt.ad_m  = addr_pins;
    q_nxt.ad_s  = q_r.ad_m;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_r <= '{scl_m: smba_pkg::LINE_IDLE, scl_s: smba_pkg::LINE_IDLE,
               scl_d: smba_pkg::LINE_IDLE, sda_m: smba_pkg::LINE_IDLE,
               sda_s: smba_pkg::LINE_IDLE, sda_d: smba_pkg::LINE_IDLE,
               ad_m: 4'h0, ad_s: 4'h0};
    end else begin
      q_r <= q_nxt;
    end
  end

  // Data moving while the clock stays high marks START or STOP
  assign line.scl       = q_r.scl_s;
  assign line.sda       = q_r.sda_s;
  assign line.scl_rise  = q_r.scl_s & ~q_r.scl_d;
  assign line.scl_fall  = ~q_r.scl_s & q_r.scl_d;
  assign line.start_det = q_r.scl_s & q_r.scl_d & q_r.sda_d & ~q_r.sda_s;
  assign line.stop_det  = q_r.scl_s & q_r.scl_d & ~q_r.sda_d & q_r.sda_s;
  assign line.addr_sel  = q_r.ad_s;

  a_start_shape: assert property (@(posedge clk) disable iff (rst)
    line.start_det |-> line.scl && !line.sda && $past(line.sda))
    else $error("START flagged without high-to-low data under high clock");
endmodule : smba_line_sync
`default_nettype wire

// [logic/smba_slave.sv]
// Summary of operation
// - Attention changes only between STOP and START
// - Power-up START holds attention until STOP
// - Separate data input and open-drain output pins
// - Slave: Write, Read and Receive Byte only
// - Primary address is 010 plus select pins
// - Broadcast address 0110000 acknowledged for writes
// - Alert address acknowledged only while attention asserted
// - START and STOP detected under high clock
// - Acknowledge holds data low through clock high
// - Write stores data byte at pointed register
// - Pointer keeps low five command bits only
// - Every STOP clears the register pointer
// - Read uses repeated START with read bit
// - Receive Byte returns register zero after STOP
// - Alert reply is own address then 1
// - Lost arbitration aborts the alert reply immediately
// - Won alert reply releases attention output
// - Attention_command_pulses bit 6 releases attention
// - No reassertion until event conditions clear
// - Attention_command_pulses bit 7 clears all events
`timescale 1ns/100ps
`default_nettype none
module smba_slave (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Serial bus pins
  input  wire logic       serial_clock_pin,
  input  wire logic       serial_data_input_pin,
  output logic            serial_data_output_pin,
  output logic            serial_data_output_pin_oe_n,
  input  wire logic [3:0] address_select_pins,
  // Attention line, open drain
  output logic            attention_pin,
  output logic            attention_pin_oe_n,
  // Device register file
  output logic [4:0]      reg_addr,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rd_data,
  // Event condition summary
  input  wire logic       event_pending,
  output logic            clear_all_events
);
  typedef struct packed {
    smba_pkg::smba_state_t st;
    logic [7:0]            sh;
    logic [3:0]            cnt;
    logic [4:0]            ptr;
    logic                  rd;
    logic                  ara;
    logic                  drive;
    logic                  busy;
    logic                  att;
    logic                  armed;
    logic                  wr;
    logic [7:0]            wdata;
    logic                  clr_all;
  } smba_core_t;

  smba_core_t  q_r;
  smba_core_t  q_nxt;
  smba_line_if line ();

  // Pin sampling and START/STOP finding
  smba_line_sync u_sync (
    .clk       (clk),
    .rst       (rst),
    .scl_pin   (serial_clock_pin),
    .sda_pin   (serial_data_input_pin),
    .addr_pins (address_select_pins),
    .line      (line.src)
  );

  logic [6:0] own_addr;
  logic [6:0] rx_addr;
  logic       hit_own;
  logic       hit_bcast;
  logic       hit_ara;
  logic       release_req;

  assign own_addr  = {smba_pkg::ADDR_HI, line.addr_sel};
  assign rx_addr   = q_r.sh[7:1];
  assign hit_own   = rx_addr == own_addr;
  // Broadcast only makes sense as a write: many slaves cannot all answer
  assign hit_bcast = (rx_addr == smba_pkg::ADDR_BCAST) && !q_r.sh[0];
  assign hit_ara   = (rx_addr == smba_pkg::ADDR_ARA) && q_r.sh[0] && q_r.att;

  // Transaction engine; bits are taken on clock rise and driven on clock fall
  always_comb begin
    q_nxt       = q_r;
    q_nxt.wr    = 1'b0;
    q_nxt.clr_all = 1'b0;
    release_req = 1'b0;
    if (line.start_det) begin
      // Repeated START keeps the pointer for the read phase
      q_nxt.st    = smba_pkg::ST_ADDR;
      q_nxt.cnt   = 4'h0;
      q_nxt.drive = 1'b0;
      q_nxt.busy  = 1'b1;
      q_nxt.rd    = 1'b0;
      q_nxt.ara   = 1'b0;
    end else if (line.stop_det) begin
      q_nxt.st    = smba_pkg::ST_IDLE;
      q_nxt.ptr   = smba_pkg::REG_EVENT;
      q_nxt.drive = 1'b0;
      q_nxt.busy  = 1'b0;
    end else begin
      unique case (q_r.st)
        smba_pkg::ST_IDLE, smba_pkg::ST_IGNORE: begin
          q_nxt.drive = 1'b0;
        end
        smba_pkg::ST_ADDR, smba_pkg::ST_CMD, smba_pkg::ST_DATA: begin
          if (line.scl_rise) begin
            q_nxt.sh  = {q_r.sh[6:0], line.sda};
            q_nxt.cnt = q_r.cnt + 4'h1;
          end else if (line.scl_fall && q_r.cnt == smba_pkg::BYTE_BITS) begin
            q_nxt.cnt = 4'h0;
            if (q_r.st == smba_pkg::ST_ADDR) begin
              if (hit_own || hit_bcast || hit_ara) begin
                q_nxt.st    = smba_pkg::ST_ADDR_ACK;
                q_nxt.drive = 1'b1;
                q_nxt.rd    = q_r.sh[0];
                q_nxt.ara   = hit_ara;
              end else begin
                q_nxt.st    = smba_pkg::ST_IGNORE;
              end
            end else if (q_r.st == smba_pkg::ST_CMD) begin
              q_nxt.ptr   = q_r.sh[smba_pkg::PTR_W-1:0];
              q_nxt.st    = smba_pkg::ST_CMD_ACK;
              q_nxt.drive = 1'b1;
            end else begin
              q_nxt.wr    = 1'b1;
              q_nxt.wdata = q_r.sh;
              q_nxt.st    = smba_pkg::ST_DATA_ACK;
              q_nxt.drive = 1'b1;
              if (q_r.ptr == smba_pkg::REG_ATTN) begin
                release_req   = q_r.sh[smba_pkg::ATTN_REL_BIT];
                q_nxt.clr_all = q_r.sh[smba_pkg::ATTN_CLR_BIT];
              end
            end
          end
        end
        smba_pkg::ST_ADDR_ACK: begin
          if (line.scl_fall) begin
            if (q_r.rd) begin
              // Alert reply carries our address, plain read carries the register
              q_nxt.st    = smba_pkg::ST_TX;
              q_nxt.sh    = q_r.ara ? {own_addr, 1'b1} : reg_rd_data;
              q_nxt.drive = q_r.ara ? !own_addr[6] : !reg_rd_data[7];
            end else begin
              q_nxt.st    = smba_pkg::ST_CMD;
              q_nxt.drive = 1'b0;
            end
          end
        end
        smba_pkg::ST_CMD_ACK: begin
          if (line.scl_fall) begin
            q_nxt.st    = smba_pkg::ST_DATA;
            q_nxt.drive = 1'b0;
          end
        end
        smba_pkg::ST_DATA_ACK: begin
          // Write Byte carries a single data byte; extra bytes are ignored
          if (line.scl_fall) begin
            q_nxt.st    = smba_pkg::ST_IGNORE;
            q_nxt.drive = 1'b0;
          end
        end
        smba_pkg::ST_TX: begin
          if (line.scl_rise) begin
            q_nxt.cnt = q_r.cnt + 4'h1;
            // Another replier with a lower address pulled the line: back off now
            if (q_r.ara && q_r.sh[7] && !line.sda) begin
              q_nxt.st    = smba_pkg::ST_IGNORE;
              q_nxt.drive = 1'b0;
            end
          end else if (line.scl_fall) begin
            if (q_r.cnt == smba_pkg::BYTE_BITS) begin
              q_nxt.st    = smba_pkg::ST_TX_ACK;
              q_nxt.drive = 1'b0;
              release_req = q_r.ara;
            end else begin
              q_nxt.sh    = {q_r.sh[6:0], 1'b1};
              q_nxt.drive = !q_r.sh[6];
            end
          end
        end
        smba_pkg::ST_TX_ACK: begin
          // Only one byte is served; the master ends with no-ack and STOP
          if (line.scl_fall) begin
            q_nxt.st = smba_pkg::ST_IGNORE;
          end
        end
        default: begin
          q_nxt.st    = smba_pkg::ST_IDLE;
          q_nxt.drive = 1'b0;
        end
      endcase
    end
    // Released attention stays off until the causing events are gone
    if (release_req) begin
      q_nxt.armed = 1'b0;
    end
    if (!event_pending || q_nxt.clr_all) begin
      q_nxt.armed = 1'b1;
    end
    // Attention moves only while no transaction is open
    if (!q_r.busy && !line.start_det) begin
      q_nxt.att = event_pending && q_r.armed;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_r <= '{st: smba_pkg::ST_IDLE, sh: 8'h00, cnt: 4'h0,
               ptr: smba_pkg::REG_EVENT, rd: 1'b0, ara: 1'b0, drive: 1'b0,
               busy: 1'b0, att: 1'b0, armed: 1'b1, wr: 1'b0, wdata: 8'h00,
               clr_all: 1'b0};
    end else begin
      q_r <= q_nxt;
    end
  end

  // Open-drain outputs: the level is always low, the enable decides
  assign serial_data_output_pin      = 1'b0;
  assign serial_data_output_pin_oe_n = !q_r.drive;
  assign attention_pin               = 1'b0;
  assign attention_pin_oe_n          = !q_r.att;
  assign reg_addr                    = q_r.ptr;
  assign reg_wr                      = q_r.wr;
  assign reg_wdata                   = q_r.wdata;
  assign clear_all_events            = q_r.clr_all;

  a_att_between_txn: assert property (@(posedge clk) disable iff (rst)
    $changed(q_r.att) |-> !$past(q_r.busy))
    else $error("Attention changed inside a transaction");

  a_att_held_busy: assert property (@(posedge clk) disable iff (rst)
    (q_r.busy && !line.stop_det) |=> $stable(q_r.att))
    else $error("Attention moved before STOP was seen");

  a_stop_ptr_zero: assert property (@(posedge clk) disable iff (rst)
    line.stop_det |=> (q_r.ptr == 5'h00) && (q_r.st == smba_pkg::ST_IDLE))
    else $error("Pointer not cleared by STOP");

  a_ack_low_high: assert property (@(posedge clk) disable iff (rst)
    (line.scl_rise && q_r.st inside {smba_pkg::ST_ADDR_ACK, smba_pkg::ST_CMD_ACK,
     smba_pkg::ST_DATA_ACK}) |-> q_r.drive ##1 q_r.drive)
    else $error("Acknowledge not held low across clock high");

  a_drive_clk_low: assert property (@(posedge clk) disable iff (rst)
    $rose(q_r.drive) |-> !line.scl)
    else $error("Data output pulled low while clock high");

  a_ara_needs_att: assert property (@(posedge clk) disable iff (rst)
    (q_r.st == smba_pkg::ST_ADDR_ACK && q_r.ara) |-> q_r.att && q_r.rd)
    else $error("Alert address answered without attention");

  a_cmd_low_bits: assert property (@(posedge clk) disable iff (rst)
    (q_r.st == smba_pkg::ST_CMD && line.scl_fall && q_r.cnt == 4'h8 && !line.start_det
     && !line.stop_det) |=> q_r.ptr == $past(q_r.sh[4:0]))
    else $error("Pointer not loaded from low command bits");

  a_arb_abort: assert property (@(posedge clk) disable iff (rst)
    (q_r.st == smba_pkg::ST_TX && q_r.ara && line.scl_rise && q_r.sh[7] && !line.sda
     && !line.start_det && !line.stop_det) |=> !q_r.drive && q_r.st == smba_pkg::ST_IGNORE)
    else $error("Lost arbitration not aborted");

  a_wr_from_data: assert property (@(posedge clk) disable iff (rst)
    q_r.wr |-> q_r.st == smba_pkg::ST_DATA_ACK && q_r.drive ##1 !q_r.wr)
    else $error("Write strobe outside data acknowledge");

  a_clear_all_rearm: assert property (@(posedge clk) disable iff (rst)
    q_r.clr_all |-> q_r.armed)
    else $error("Clear-all did not re-arm attention");

  a_release_holds: assert property (@(posedge clk) disable iff (rst)
    ($fell(q_r.armed) && event_pending) |=> !q_r.armed || !event_pending)
    else $error("Attention re-armed while events still pending");
endmodule : smba_slave
`default_nettype wire

// [dv/smba_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Host master; clock stands high between frames, data line has a pull-up
module smba_host_model (
  // Clock
  input  wire logic clk,
  // Bus wires
  output logic      scl,
  output logic      sda,
  input  wire logic oe_n
);
  logic       drv_low; // Master pulls data low
  logic       riv_low; // Rival slave pulls data low
  logic [7:0] rival;   // Rival alert reply, all ones when absent

  // Wired AND of every pull-down, so a released line reads high
  assign sda = !(drv_low | riv_low | !oe_n);

  initial begin
    scl     = 1'b1;
    drv_low = 1'b0;
    riv_low = 1'b0;
    rival   = 8'hff;
  end

  task automatic hw(input int n);
    repeat (n) @(posedge clk);
  endtask : hw

  // START, or repeated START when the clock is low
  task automatic sta();
    drv_low <= 1'b0;
    hw(2);
    scl <= 1'b1;
    hw(5);
    drv_low <= 1'b1;
    hw(5);
    scl <= 1'b0;
    hw(3);
  endtask : sta

  // STOP, after which both lines stay high
  task automatic sto();
    drv_low <= 1'b1;
    hw(2);
    scl <= 1'b1;
    hw(5);
    drv_low <= 1'b0;
    hw(5);
  endtask : sto

  // One 80 ns clock; a level that moves while high reads as unknown
  task automatic bx(input logic b, input logic rb, output logic r);
    logic s;
    drv_low <= !b;
    riv_low <= !rb;
    hw(2);
    scl <= 1'b1;
    hw(1);
    #2 s = sda;
    hw(3);
    r = (sda === s) ? s : 1'bx;
    scl <= 1'b0;
    hw(4);
  endtask : bx

  // Eight bits MSB first, then a ninth clock with the master released
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bx(d[i], rival[i], r);
      q[i] = r;
    end
    bx(1'b1, 1'b1, a);
  endtask : xfer
endmodule : smba_host_model
`default_nettype wire

// [dv/test_smbus_slave_with_alert.sv]
`timescale 1ns/100ps
`default_nettype none
module test_smbus_slave_with_alert;
  localparam logic [6:0] own_addr   = 7'h25; // 010 then select pins 5
  localparam logic [6:0] alert_addr = 7'h0c;
  // Bus and pins
  logic       clk;
  logic       rst;
  wire        scl;
  wire        sda;
  logic       oe_n;
  logic       attn_n;
  logic [3:0] addr_sel;
  // Register side
  logic [4:0] reg_addr;
  logic       reg_wr;
  logic [7:0] reg_wdata;
  logic       ev;
  logic       clr;
  logic [7:0] regs [32];
  int         n_clr;
  int         bad_count;
  int         samples_checked;

  smba_host_model u_host (
    .clk  (clk),
    .scl  (scl),
    .sda  (sda),
    .oe_n (oe_n)
  );

  smba_slave u_dut (
    .clk                         (clk),
    .rst                         (rst),
    .serial_clock_pin            (scl),
    .serial_data_input_pin       (sda),
    .serial_data_output_pin      (),
    .serial_data_output_pin_oe_n (oe_n),
    .address_select_pins         (addr_sel),
    .attention_pin               (),
    .attention_pin_oe_n          (attn_n),
    .reg_addr                    (reg_addr),
    .reg_wr                      (reg_wr),
    .reg_wdata                   (reg_wdata),
    .reg_rd_data                 (regs[reg_addr]),
    .event_pending               (ev),
    .clear_all_events            (clr)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Register file and the event conditions behind attention
  always @(posedge clk) begin
    if (reg_wr) begin
      regs[reg_addr] <= reg_wdata;
    end
    if (clr) begin
      ev    <= 1'b0;
      n_clr <= n_clr + 1;
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic results();
    $display("Checks made %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  // Byte to the device; its ack level is compared
  task automatic tx(input logic [7:0] d, input logic ea, input string nm);
    logic [7:0] q;
    logic       a;
    u_host.xfer(d, q, a);
    chk(nm, {7'h00, ea}, {7'h00, a});
  endtask : tx

  // Byte from the device, left unacknowledged by the master
  task automatic rx(input logic [7:0] e, input string nm);
    logic [7:0] q;
    logic       a;
    u_host.xfer(8'hff, q, a);
    chk(nm, e, q);
  endtask : rx

  task automatic wr_reg(input logic [7:0] c, input logic [7:0] d);
    u_host.sta();
    tx({own_addr, 1'b0}, 1'b0, "wr addr");
    tx(c, 1'b0, "wr cmd");
    tx(d, 1'b0, "wr data");
    u_host.sto();
  endtask : wr_reg

  // Bounded wait for the attention level, a hang ends the run
  task automatic wait_attn(input logic e, input string nm);
    int i;
    i = 0;
    while (i < 40 && attn_n !== e) begin
      @(posedge clk);
      i++;
    end
    chk(nm, {7'h00, e}, {7'h00, attn_n});
    // Only a bound used up without a match ends the run early
    if (attn_n !== e) begin
      results();
    end
  endtask : wait_attn

  // START with no STOP after power-up holds attention back
  task automatic t_powerup();
    u_host.sta();
    ev <= 1'b1;
    u_host.hw(30);
    chk("attn in frame", 8'h01, {7'h00, attn_n});
    u_host.sto();
    wait_attn(1'b0, "attn after stop");
  endtask : t_powerup

  // Write with upper command bits set, read back, receive byte
  task automatic t_xfer();
    wr_reg(8'he3, 8'h5a);
    chk("reg 3", 8'h5a, regs[3]);
    chk("pointer", 8'h00, {3'h0, reg_addr});
    u_host.sta();
    tx({own_addr, 1'b0}, 1'b0, "rd addr");
    tx(8'h03, 1'b0, "rd cmd");
    u_host.sta();
    tx({own_addr, 1'b1}, 1'b0, "rd addr r");
    rx(8'h5a, "rd byte");
    u_host.sto();
    u_host.sta();
    tx({own_addr, 1'b1}, 1'b0, "recv addr");
    rx(8'hc3, "recv byte");
    u_host.sto();
  endtask : t_xfer

  // Broadcast write lands; broadcast read and foreign address refused
  task automatic t_addr();
    u_host.sta();
    tx(8'h60, 1'b0, "bcast addr");
    tx(8'h04, 1'b0, "bcast cmd");
    tx(8'h77, 1'b0, "bcast data");
    u_host.sto();
    chk("reg 4", 8'h77, regs[4]);
    u_host.sta();
    tx(8'h61, 1'b1, "bcast read");
    u_host.sto();
    u_host.sta();
    tx(8'h4c, 1'b1, "other addr");
    u_host.sto();
    addr_sel <= 4'ha;
    u_host.sta();
    tx(8'h55, 1'b0, "new select");
    rx(8'hc3, "new select byte");
    u_host.sto();
    addr_sel <= 4'h5;
  endtask : t_addr

  // Alert reply: refused write, lost arbitration, win, release, re-arm
  task automatic t_alert();
    u_host.sta();
    tx({alert_addr, 1'b0}, 1'b1, "alert write");
    u_host.sto();
    u_host.sta();
    tx({alert_addr, 1'b1}, 1'b0, "alert ack");
    u_host.rival = 8'h47;
    rx(8'h47, "alert lost");
    u_host.rival = 8'hff;
    u_host.sto();
    u_host.hw(20);
    chk("attn kept", 8'h00, {7'h00, attn_n});
    u_host.sta();
    tx({alert_addr, 1'b1}, 1'b0, "alert ack 2");
    rx({own_addr, 1'b1}, "alert reply");
    u_host.sto();
    wait_attn(1'b1, "attn released");
    u_host.hw(20);
    chk("attn stays off", 8'h01, {7'h00, attn_n});
    u_host.sta();
    tx({alert_addr, 1'b1}, 1'b1, "alert idle");
    u_host.sto();
    wr_reg(8'h1a, 8'h80);
    chk("clear pulses", 8'h01, n_clr[7:0]);
    ev <= 1'b1;
    wait_attn(1'b0, "attn rearmed");
    wr_reg(8'h1a, 8'h40);
    wait_attn(1'b1, "attn off by write");
    chk("clear pulses 2", 8'h01, n_clr[7:0]);
  endtask : t_alert

  initial begin
    rst             = 1'b1;
    addr_sel        = 4'h5;
    ev              = 1'b0;
    n_clr           = 0;
    bad_count       = 0;
    samples_checked = 0;
    for (int i = 0; i < 32; i++) begin
      regs[i] = 8'h00;
    end
    regs[0] = 8'hc3;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    u_host.hw(4);
    t_powerup();
    t_xfer();
    t_addr();
    t_alert();
    results();
  end
endmodule : test_smbus_slave_with_alert
`default_nettype wire
